// File: hw/async_serial_port_9bit_pkg.sv
// constants for the asynchronous serial port with 8-bit and 9-bit frames
//
// Summary of operation
// - mode bit picks 8-bit or 9-bit frames
// - 8-bit frame: start, eight data LSB first, stop
// - 8-bit mode: byte to latch, stop to flag
// - buffer write starts a new transmit frame
// - tx done set at start of stop bit
// - receiver accepts frames only while enabled
// - 8-bit load needs done clear, stop if filtering
// - overrun keeps first byte, later frame lost
// - failed load changes neither latch, flag, nor done
// - interrupt request while enabled and either done flag set
// - 9-bit frame: start, eight data, ninth, stop
// - transmitted ninth bit follows tx ninth flag
// - 9-bit mode: ninth to flag, stop ignored
// - 9-bit load needs done clear, ninth if filtering
// - filtered 9-bit mode flags only address frames
// - control bit six reads one, ignores writes
// - only software clears the done flags
// - buffer reads latch, writes go to transmitter
// - bit rate is timer overflow rate halved
// - start edge forces receive timer reload
package async_serial_port_9bit_pkg;

    // **********************************************************
    // register addresses and reset values
    // **********************************************************
    localparam logic [7:0] CTRL_ADDR  = 8'h98;
    localparam logic [7:0] BUF_ADDR   = 8'h99;
    localparam logic [7:0] CTRL_RESET = 8'h40;
    localparam logic [7:0] BUF_RESET  = 8'h00;

    // **********************************************************
    // control register field positions
    // **********************************************************
    localparam int MODE_BIT   = 7;
    localparam int UNUSED_BIT = 6;
    localparam int MCE_BIT    = 5;
    localparam int REN_BIT    = 4;
    localparam int TB8_BIT    = 3;
    localparam int RB8_BIT    = 2;
    localparam int TI_BIT     = 1;
    localparam int RI_BIT     = 0;

    // **********************************************************
    // frame and timer counts
    // **********************************************************
    localparam logic [2:0] LAST_DATA_BIT = 3'h7;
    localparam logic [7:0] TMR_TOP       = 8'hFF;

endpackage

// File: hw/async_serial_port_9bit.sv
// full-duplex serial port with 8-bit and 9-bit frames and address filter
`timescale 1ns/100ps
`default_nettype none

module async_serial_port_9bit
    import async_serial_port_9bit_pkg::*;
(
    // clock and reset
    input  wire logic       I_SYS_CLK,
    input  wire logic       I_SYS_RST,
    // special function register access
    input  wire logic [7:0] I_SFR_ADDR,
    input  wire logic       I_SFR_WR,
    input  wire logic [7:0] I_SFR_WDATA,
    input  wire logic       I_SFR_RD,
    output logic      [7:0] O_SFR_RDATA,
    // bit rate timer
    input  wire logic       I_TMR_OVF,
    input  wire logic       I_TMR_TICK,
    input  wire logic       I_TMR_RUN,
    input  wire logic [7:0] I_TMR_RELOAD,
    // interrupt
    input  wire logic       I_INT_ENABLE,
    output logic            O_IRQ,
    // serial pins
    output logic            O_TX_PIN,
    input  wire logic       I_RX_PIN
);

    typedef enum logic [2:0] {T_IDLE, T_START, T_DATA, T_NINTH, T_STOP} tx_state_t;
    typedef enum logic [2:0] {R_IDLE, R_START, R_DATA, R_NINTH, R_STOP} rx_state_t;

    // **********************************************************
    // control register and read path
    // **********************************************************
    logic       mode, next_mode;
    logic       mce, next_mce;
    logic       ren, next_ren;
    logic       tb8, next_tb8;
    logic       rb8, next_rb8;
    logic       ti, next_ti;
    logic       ri, next_ri;
    logic [7:0] rx_latch, next_rx_latch;
    logic [7:0] rdata, next_rdata;
    logic       irq, next_irq;
    logic       ctrl_wr, buf_wr;
    logic [7:0] ctrl_value;

    // **********************************************************
    // transmitter and receiver state
    // **********************************************************
    tx_state_t  tx_state, next_tx_state;
    logic       tx_div, next_tx_div;
    logic       tx_tick;
    logic       tx_pending, next_tx_pending;
    logic [7:0] tx_data, next_tx_data;
    logic [7:0] tx_shift, next_tx_shift;
    logic [2:0] tx_cnt, next_tx_cnt;
    logic       tx_pin, next_tx_pin;
    logic       tx_set;
    logic       rx_s1, rx_s2, rx_s3;
    logic       rx_level, next_rx_level;
    logic       rx_fall;
    rx_state_t  rx_state, next_rx_state;
    logic [7:0] rx_timer, next_rx_timer;
    logic       rx_ovf;
    logic       rx_phase, next_rx_phase;
    logic       rx_sample;
    logic       start_det;
    logic [7:0] rx_shift, next_rx_shift;
    logic [2:0] rx_cnt, next_rx_cnt;
    logic       rx_ninth, next_rx_ninth;
    logic       rx_load, rx_bit9, rx_qual;

    assign ctrl_wr    = I_SFR_WR && (I_SFR_ADDR == CTRL_ADDR);
    assign buf_wr     = I_SFR_WR && (I_SFR_ADDR == BUF_ADDR);
    assign ctrl_value = {mode, 1'b1, mce, ren, tb8, rb8, ti, ri};

    assign O_SFR_RDATA = rdata;
    assign O_IRQ       = irq;
    assign O_TX_PIN    = tx_pin;

    // **********************************************************
    // control register
    // **********************************************************
    always_comb begin
        next_mode     = mode;
        next_mce      = mce;
        next_ren      = ren;
        next_tb8      = tb8;
        next_rb8      = rb8;
        next_ti       = ti;
        next_ri       = ri;
        next_rx_latch = rx_latch;
        next_rdata    = rdata;
        if (ctrl_wr) begin
            next_mode = I_SFR_WDATA[MODE_BIT];
            next_mce  = I_SFR_WDATA[MCE_BIT];
            next_ren  = I_SFR_WDATA[REN_BIT];
            next_tb8  = I_SFR_WDATA[TB8_BIT];
            next_rb8  = I_SFR_WDATA[RB8_BIT];
            next_ti   = I_SFR_WDATA[TI_BIT];
            next_ri   = I_SFR_WDATA[RI_BIT];
        end
        // hardware only sets the done flags, and a set beats a clear
        if (tx_set) begin
            next_ti = 1'b1;
        end
        if (rx_load) begin
            next_ri       = 1'b1;
            next_rb8      = rx_bit9;
            next_rx_latch = rx_shift;
        end
        if (I_SFR_RD) begin
            if (I_SFR_ADDR == CTRL_ADDR) begin
                next_rdata = ctrl_value;
            end else if (I_SFR_ADDR == BUF_ADDR) begin
                next_rdata = rx_latch;
            end else begin
                next_rdata = 8'h00;
            end
        end
        next_irq = I_INT_ENABLE && (next_ti || next_ri);
    end

    always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            mode     <= CTRL_RESET[MODE_BIT];
            mce      <= CTRL_RESET[MCE_BIT];
            ren      <= CTRL_RESET[REN_BIT];
            tb8      <= CTRL_RESET[TB8_BIT];
            rb8      <= CTRL_RESET[RB8_BIT];
            ti       <= CTRL_RESET[TI_BIT];
            ri       <= CTRL_RESET[RI_BIT];
            rx_latch <= BUF_RESET;
            rdata    <= 8'h00;
            irq      <= 1'b0;
        end else begin
            mode     <= next_mode;
            mce      <= next_mce;
            ren      <= next_ren;
            tb8      <= next_tb8;
            rb8      <= next_rb8;
            ti       <= next_ti;
            ri       <= next_ri;
            rx_latch <= next_rx_latch;
            rdata    <= next_rdata;
            irq      <= next_irq;
        end
    end

    // **********************************************************
    // transmitter
    // **********************************************************
    assign tx_tick = I_TMR_OVF && tx_div;

    always_comb begin
        next_tx_div     = I_TMR_OVF ? !tx_div : tx_div;
        next_tx_state   = tx_state;
        next_tx_pending = tx_pending;
        next_tx_data    = tx_data;
        next_tx_shift   = tx_shift;
        next_tx_cnt     = tx_cnt;
        next_tx_pin     = tx_pin;
        tx_set          = 1'b0;
        if (tx_tick) begin
            case (tx_state)
                T_START: begin
                    next_tx_pin   = tx_shift[0];
                    next_tx_shift = {1'b0, tx_shift[7:1]};
                    next_tx_cnt   = 3'h0;
                    next_tx_state = T_DATA;
                end
                T_DATA: begin
                    if (tx_cnt == LAST_DATA_BIT) begin
                        if (mode) begin
                            next_tx_pin   = tb8;
                            next_tx_state = T_NINTH;
                        end else begin
                            next_tx_pin   = 1'b1;
                            tx_set        = 1'b1;
                            next_tx_state = T_STOP;
                        end
                    end else begin
                        next_tx_pin   = tx_shift[0];
                        next_tx_shift = {1'b0, tx_shift[7:1]};
                        next_tx_cnt   = tx_cnt + 3'h1;
                    end
                end
                T_NINTH: begin
                    next_tx_pin   = 1'b1;
                    tx_set        = 1'b1;
                    next_tx_state = T_STOP;
                end
                default: begin
                    // idle or end of stop bit: begin a waiting frame
                    next_tx_pin   = 1'b1;
                    next_tx_state = T_IDLE;
                    if (tx_pending) begin
                        next_tx_pin     = 1'b0;
                        next_tx_shift   = tx_data;
                        next_tx_pending = 1'b0;
                        next_tx_state   = T_START;
                    end
                end
            endcase
        end
        if (buf_wr) begin
            next_tx_data    = I_SFR_WDATA;
            next_tx_pending = 1'b1;
        end
    end

    always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            tx_state   <= T_IDLE;
            tx_div     <= 1'b0;
            tx_pending <= 1'b0;
            tx_data    <= 8'h00;
            tx_shift   <= 8'h00;
            tx_cnt     <= 3'h0;
            tx_pin     <= 1'b1;
        end else begin
            tx_state   <= next_tx_state;
            tx_div     <= next_tx_div;
            tx_pending <= next_tx_pending;
            tx_data    <= next_tx_data;
            tx_shift   <= next_tx_shift;
            tx_cnt     <= next_tx_cnt;
            tx_pin     <= next_tx_pin;
        end
    end

    // **********************************************************
    // receive pin synchroniser and receive timer
    // **********************************************************
    assign next_rx_level = (rx_s2 == rx_s3) ? rx_s2 : rx_level;
    assign rx_fall       = rx_level && (rx_s2 == rx_s3) && !rx_s2;
    assign start_det     = (rx_state == R_IDLE) && ren && rx_fall;
    assign rx_ovf        = I_TMR_RUN && I_TMR_TICK && (rx_timer == TMR_TOP);
    assign rx_sample     = rx_ovf && !rx_phase;

    always_comb begin
        next_rx_timer = rx_timer;
        if (start_det) begin
            next_rx_timer = I_TMR_RELOAD;
        end else if (I_TMR_RUN && I_TMR_TICK) begin
            next_rx_timer = (rx_timer == TMR_TOP) ? I_TMR_RELOAD : rx_timer + 8'h01;
        end
    end

    // **********************************************************
    // receiver
    // **********************************************************
    always_comb begin
        next_rx_state = rx_state;
        next_rx_shift = rx_shift;
        next_rx_cnt   = rx_cnt;
        next_rx_ninth = rx_ninth;
        next_rx_phase = rx_ovf ? !rx_phase : rx_phase;
        rx_load       = 1'b0;
        rx_bit9       = mode ? rx_ninth : rx_level;
        rx_qual       = !ri && (!mce || rx_bit9);
        case (rx_state)
            R_IDLE: begin
                if (start_det) begin
                    // first overflow after reload falls mid start bit
                    next_rx_phase = 1'b0;
                    next_rx_state = R_START;
                end
            end
            R_START: begin
                if (rx_sample) begin
                    next_rx_cnt   = 3'h0;
                    next_rx_state = rx_level ? R_IDLE : R_DATA;
                end
            end
            R_DATA: begin
                if (rx_sample) begin
                    next_rx_shift = {rx_level, rx_shift[7:1]};
                    next_rx_cnt   = rx_cnt + 3'h1;
                    if (rx_cnt == LAST_DATA_BIT) begin
                        next_rx_state = mode ? R_NINTH : R_STOP;
                    end
                end
            end
            R_NINTH: begin
                if (rx_sample) begin
                    next_rx_ninth = rx_level;
                    next_rx_state = R_STOP;
                end
            end
            R_STOP: begin
                if (rx_sample) begin
                    rx_load       = rx_qual;
                    next_rx_state = R_IDLE;
                end
            end
            default: begin
                next_rx_state = R_IDLE;
            end
        endcase
        if (!ren) begin
            next_rx_state = R_IDLE;
        end
    end

    always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            rx_s1    <= 1'b1;
            rx_s2    <= 1'b1;
            rx_s3    <= 1'b1;
            rx_level <= 1'b1;
            rx_timer <= 8'h00;
            rx_phase <= 1'b0;
            rx_state <= R_IDLE;
            rx_shift <= 8'h00;
            rx_cnt   <= 3'h0;
            rx_ninth <= 1'b0;
        end else begin
            rx_s1    <= I_RX_PIN;
            rx_s2    <= rx_s1;
            rx_s3    <= rx_s2;
            rx_level <= next_rx_level;
            rx_timer <= next_rx_timer;
            rx_phase <= next_rx_phase;
            rx_state <= next_rx_state;
            rx_shift <= next_rx_shift;
            rx_cnt   <= next_rx_cnt;
            rx_ninth <= next_rx_ninth;
        end
    end

endmodule

`default_nettype wire

// File: test/async_serial_port_9bit_asserts.sv
// property checker watching the serial port top ports
`timescale 1ns/100ps
`default_nettype none
module async_serial_port_9bit_asserts
    import async_serial_port_9bit_pkg::*;
(
    // clock and reset
    input wire logic       I_SYS_CLK,
    input wire logic       I_SYS_RST,
    // register port
    input wire logic [7:0] I_SFR_ADDR,
    input wire logic       I_SFR_WR,
    input wire logic       I_SFR_RD,
    input wire logic [7:0] O_SFR_RDATA,
    // timer, interrupt, pin
    input wire logic       I_TMR_OVF,
    input wire logic       I_INT_ENABLE,
    input wire logic       O_IRQ,
    input wire logic       O_TX_PIN
);
    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (I_SYS_RST);
    logic ctl_rd;
    logic ctl_wr;
    assign ctl_rd = I_SFR_RD && I_SFR_ADDR == CTRL_ADDR;
    assign ctl_wr = I_SFR_WR && I_SFR_ADDR == CTRL_ADDR;
    property p_bit6;
        ctl_rd |=> O_SFR_RDATA[6];
    endproperty
    a_bit6: assert property (p_bit6) else $error("bit six read low");
    property p_unmapped;
        I_SFR_RD && I_SFR_ADDR != CTRL_ADDR && I_SFR_ADDR != BUF_ADDR |=> O_SFR_RDATA == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");
    property p_rd_hold;
        !I_SFR_RD |=> $stable(O_SFR_RDATA);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
    property p_irq_read;
        ctl_rd && I_INT_ENABLE && !I_SFR_WR |=> O_SFR_RDATA[1:0] == 2'h0 || O_IRQ;
    endproperty
    a_irq_read: assert property (p_irq_read) else $error("flag set, no request");
    property p_irq_rise;
        $rose(O_IRQ) |-> $past(I_INT_ENABLE);
    endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("request while disabled");
    property p_irq_hold;
        O_IRQ && I_INT_ENABLE && !ctl_wr |=> O_IRQ;
    endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("flag cleared by hardware");
    property p_tx_start;
        I_SFR_WR && I_SFR_ADDR == BUF_ADDR |-> ##[1:200] !O_TX_PIN;
    endproperty
    a_tx_start: assert property (p_tx_start) else $error("no frame after write");
    property p_tx_edge;
        $changed(O_TX_PIN) |-> $past(I_TMR_OVF);
    endproperty
    a_tx_edge: assert property (p_tx_edge) else $error("pin moved off a tick");
endmodule
`default_nettype wire

// File: test/serial_far_end.sv
// far serial node: sends frames to the port and decodes its output
`timescale 1ns/100ps
`default_nettype none
module serial_far_end #(
    parameter int BIT_CLKS = 8
) (
    // clock
    input  wire logic i_clk,
    // serial lines and frame format
    input  wire logic i_tx_line,
    input  wire logic i_nine,
    output var logic  o_rx_line
);
    logic [9:0] got_q[$];
    initial o_rx_line = 1'b1;
    task automatic send(input logic [7:0] d, input logic b9, input logic stp);
        logic [10:0] f;
        f = i_nine ? {stp, b9, d, 1'b0} : {1'b1, stp, d, 1'b0};
        @(posedge i_clk);
        for (int i = 0; i < (i_nine ? 11 : 10); i++) begin
            o_rx_line <= f[i];
            repeat (BIT_CLKS) @(posedge i_clk);
        end
        o_rx_line <= 1'b1;
    endtask
    // mid-bit sampling of the port output, {stop, ninth, data}
    always begin : watch
        logic [9:0] s;
        @(negedge i_tx_line);
        repeat (BIT_CLKS / 2) @(posedge i_clk);
        s = 10'h3FF;
        for (int i = 0; i < (i_nine ? 10 : 9); i++) begin
            repeat (BIT_CLKS) @(posedge i_clk);
            s[i] = i_tx_line;
        end
        if (!i_nine) s[9] = s[8];
        got_q.push_back(s);
    end
endmodule
`default_nettype wire

// File: test/async_serial_port_9bit_tb.sv
// self-checking bench for the serial port
`timescale 1ns/100ps
`default_nettype none
module async_serial_port_9bit_tb
    import async_serial_port_9bit_pkg::*;
;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  addr = 8'h00;
    logic        wr_s = 1'b0;
    logic [7:0]  wdata = 8'h00;
    logic        rd_s = 1'b0;
    logic        ovf = 1'b0;
    logic [1:0]  ovf_cnt = 2'h0;
    logic        int_en = 1'b0;
    logic        mode_v = 1'b0;
    logic [7:0]  rdata;
    logic        irq;
    logic        tx;
    logic        rx;
    logic [31:0] seed = 32'h6130FD65;
    int          miscompares = 0;
    int          total_checks = 0;
    logic [7:0]  e_latch = 8'h00;
    logic        e_rb8 = 1'b0;
    logic        e_ri = 1'b0;
    initial forever #2.5 clk = ~clk;
    always @(posedge clk) begin
        ovf_cnt <= ovf_cnt + 2'h1;
        ovf <= (ovf_cnt == 2'h3);
    end
    async_serial_port_9bit dut_u (
        .I_SYS_CLK(clk), .I_SYS_RST(rst), .I_SFR_ADDR(addr), .I_SFR_WR(wr_s),
        .I_SFR_WDATA(wdata), .I_SFR_RD(rd_s), .O_SFR_RDATA(rdata), .I_TMR_OVF(ovf),
        .I_TMR_TICK(1'b1), .I_TMR_RUN(1'b1), .I_TMR_RELOAD(8'hFC),
        .I_INT_ENABLE(int_en), .O_IRQ(irq), .O_TX_PIN(tx), .I_RX_PIN(rx));
    serial_far_end #(.BIT_CLKS(8)) far_u (
        .i_clk(clk), .i_tx_line(tx), .i_nine(mode_v), .o_rx_line(rx));
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic ld_ok(input logic ri, input logic mce, input logic q);
        return !ri && (!mce || q);
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        @(negedge clk);
        chk(rdata, exp);
    endtask
    task automatic end_sim();
        $display("checks %0d, miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge clk);
        miscompares++;
        end_sim();
    end
    initial begin : main
        logic [31:0] r;
        logic [9:0]  got;
        logic        m;
        logic        ren;
        logic        q;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rd(CTRL_ADDR, CTRL_RESET);
        rd(BUF_ADDR, BUF_RESET);
        wr(CTRL_ADDR, 8'h00);
        wr(8'h9A, 8'hFF);
        int_en <= 1'b1;
        rd(8'h9A, 8'h00);
        rd(CTRL_ADDR, 8'h40);
        $display("test registers done");
        for (int i = 0; i < 6; i++) begin
            r = rnd();
            m = r[0];
            mode_v = m;
            wr(CTRL_ADDR, {m, 3'h0, r[1], 3'h0});
            wr(BUF_ADDR, r[15:8]);
            for (int k = 0; k < 300 && far_u.got_q.size() == 0; k++) @(posedge clk);
            got = (far_u.got_q.size() > 0) ? far_u.got_q.pop_front() : 10'h000;
            chk(got[7:0], r[15:8]);
            chk({7'h0, got[9]}, 8'h01);
            chk({7'h0, got[8]}, {7'h0, m ? r[1] : 1'b1});
            rd(CTRL_ADDR, {m, 1'b1, 2'h0, r[1], 3'h2});
            rd(BUF_ADDR, e_latch);
            chk({7'h0, irq}, 8'h01);
        end
        $display("test transmit done");
        for (int i = 0; i < 14; i++) begin
            r = rnd();
            m = r[0];
            ren = (i != 4);
            q = m ? r[2] : r[3];
            if (r[5]) e_ri = 1'b0;
            mode_v = m;
            wr(CTRL_ADDR, {m, 1'b0, r[1], ren, 1'b0, e_rb8, 1'b0, e_ri});
            int_en <= r[4];
            far_u.send(r[15:8], r[2], m | r[3]);
            repeat (12) @(posedge clk);
            if (ren && ld_ok(e_ri, r[1], q)) begin
                e_latch = r[15:8];
                e_rb8 = q;
                e_ri = 1'b1;
            end
            rd(BUF_ADDR, e_latch);
            rd(CTRL_ADDR, {m, 1'b1, r[1], ren, 1'b0, e_rb8, 1'b0, e_ri});
            chk({7'h0, irq}, {7'h0, r[4] & e_ri});
        end
        $display("test receive done");
        end_sim();
    end
endmodule
bind async_serial_port_9bit async_serial_port_9bit_asserts chk_u (
    .I_SYS_CLK(I_SYS_CLK), .I_SYS_RST(I_SYS_RST), .I_SFR_ADDR(I_SFR_ADDR),
    .I_SFR_WR(I_SFR_WR), .I_SFR_RD(I_SFR_RD), .O_SFR_RDATA(O_SFR_RDATA),
    .I_TMR_OVF(I_TMR_OVF), .I_INT_ENABLE(I_INT_ENABLE), .O_IRQ(O_IRQ), .O_TX_PIN(O_TX_PIN));
`default_nettype wire
